// ==== src/smbus_register_access_slave.sv ====
// serial bus register access slave with its write-command fifo
// Notes on behaviour
// - slave address is 7 bits: fixed 01011 plus two select-pin bits
// - select pin: ground gives 10, open gives 00, supply gives 01
// - select pin left open means the slave answers to 0101100
// - select pin caught once after power-up; later changes ignored
// - start is data falling while clock high; restarts receive sequence
// - after start, eight bits msb first: address then direction bit
// - on own address drive ack low before ninth pulse, else stay idle
// - direction 0 means master writes, 1 means master reads
// - each byte is nine pulses: eight data plus acknowledge
// - data changes only while clock low; rise while clock high is stop
// - direction fixed by the address byte; change needs new start
// - writes carry one or two bytes; reads return one byte
// - first written byte after the address loads the pointer
// - second written byte goes to the register the pointer selects
// - a one-byte write only moves the pointer
// - a read sends one byte from the register the pointer selects
// - read without pointer write uses old pointer; no write without it
// - pointer write, repeated start, single byte read is supported
// - pointer selects the register for every data access
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////
// flip-flop fifo, index addressed
module reg_write_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_idx_r;
    logic [AW-1:0]    rd_idx_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // honest full and empty straight from the fill count
    assign in_ready_out  = (count_r != (AW+1)'(DEPTH));
    assign out_valid_out = (count_r != '0);
    assign out_data_out  = mem_r[rd_idx_r];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    // storage has no reset; only written words are ever read
    always_ff @(posedge core_clk_in)
    begin
        if (push)
            mem_r[wr_idx_r] <= in_data_in;
    end

    // pointers and fill count
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_idx_r <= (wr_idx_r == AW'(DEPTH-1)) ? '0 : wr_idx_r + 1'b1;
            if (pop)
                rd_idx_r <= (rd_idx_r == AW'(DEPTH-1)) ? '0 : rd_idx_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end
endmodule // reg_write_fifo

////////////////////////////////////////////////////////////////////////////
// bus slave: start/stop, address match, pointer and data sequencing
module smbus_register_access_slave
    import smbus_slave_pkg::*;
#(
    parameter int FIFO_DEPTH = WR_FIFO_DEPTH
) (
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [1:0] address_select_pin_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic [7:0]      reg_pointer_out,
    input  wire logic [7:0] reg_rd_data_in,
    output logic            reg_wr_valid_out,
    input  wire logic       reg_wr_ready_in,
    output reg_write_s      reg_wr_out,
    output logic [6:0]      own_addr_out
);

    // select pin decode, tolerant of an unknown code by reading it as open
    function automatic logic [1:0] sel_to_low(input logic [1:0] sel);
        case (sel)
            SEL_GND: sel_to_low = LOW_FOR_GND;
            SEL_VCC: sel_to_low = LOW_FOR_VCC;
            default: sel_to_low = LOW_FOR_OPEN;
        endcase
    endfunction

    logic [2:0]  scl_sync_r;
    logic [2:0]  sda_sync_r;
    logic [1:0]  sel_s1_r;
    logic [1:0]  sel_s2_r;
    logic [1:0]  sel_s3_r;
    logic        scl_f_r;
    logic        sda_f_r;
    logic        scl_now;
    logic        sda_now;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic [2:0]  settle_r;
    logic        latched_r;
    logic [1:0]  addr_low_r;
    logic [6:0]  own_addr;
    bus_state_e  state_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [1:0]  byte_idx_r;
    logic        sda_oe_r;
    logic [7:0]  ptr_r;
    logic        byte_done;
    logic        fifo_in_ready;
    logic        wr_push;
    reg_write_s  wr_cmd;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; only stages two and three are looked at
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
            sel_s1_r   <= 2'h0;
            sel_s2_r   <= 2'h0;
            sel_s3_r   <= 2'h0;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[1:0], scl_in};
            sda_sync_r <= {sda_sync_r[1:0], sda_in};
            sel_s1_r   <= address_select_pin_in;
            sel_s2_r   <= sel_s1_r;
            sel_s3_r   <= sel_s2_r;
        end
    end

    // a level counts once stages two and three agree
    assign scl_now = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_f_r;
    assign sda_now = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_f_r;

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
        end
        else
        begin
            scl_f_r <= scl_now;
            sda_f_r <= sda_now;
        end
    end

    // clock edges and bus conditions on the filtered levels
    assign scl_rise  = scl_now && !scl_f_r;
    assign scl_fall  = !scl_now && scl_f_r;
    assign start_det = scl_now && scl_f_r && sda_f_r && !sda_now;
    assign stop_det  = scl_now && scl_f_r && !sda_f_r && sda_now;

    ////////////////////////////////////////////////////////////////////////
    // address select caught once after reset release, then frozen
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            settle_r   <= 3'h0;
            latched_r  <= 1'b0;
            addr_low_r <= LOW_FOR_OPEN;
        end
        else if (!latched_r)
        begin
            if (settle_r == SEL_SETTLE && sel_s2_r == sel_s3_r)
            begin
                latched_r  <= 1'b1;
                addr_low_r <= sel_to_low(sel_s3_r);
            end
            else if (settle_r != SEL_SETTLE)
                settle_r <= settle_r + 3'h1;
        end
    end

    assign own_addr     = {ADDR_FIXED, addr_low_r};
    assign own_addr_out = own_addr;

    ////////////////////////////////////////////////////////////////////////
    // a data byte is complete on the fall after its eighth rise
    assign byte_done = scl_fall && (bit_cnt_r == BITS_PER_BYTE);

    // the second write byte is queued only if the fifo has room;
    // a full fifo shows to the master as a missing acknowledge
    assign wr_cmd.addr = ptr_r;
    assign wr_cmd.data = shift_r;
    assign wr_push     = (state_r == ST_WR_BYTE) && byte_done &&
                         (byte_idx_r == IDX_DATA) && fifo_in_ready;

    // bus sequencer; start and stop win over any clock edge
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_r    <= ST_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            byte_idx_r <= IDX_POINTER;
            sda_oe_r   <= 1'b0;
            ptr_r      <= POINTER_RESET;
        end
        else if (!latched_r)
        begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end
        else if (start_det)
        begin
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_oe_r  <= 1'b0;
        end
        else if (stop_det)
        begin
            state_r  <= ST_IDLE;
            sda_oe_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        shift_r   <= {shift_r[6:0], sda_now};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        if (shift_r[7:1] == own_addr)
                        begin
                            sda_oe_r <= 1'b1;
                            state_r  <= ST_ADDR_ACK;
                        end
                        else
                            state_r  <= ST_IGNORE;
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_r  <= 4'h0;
                        byte_idx_r <= IDX_POINTER;
                        if (shift_r[0])
                        begin
                            // first read bit goes out as the ack ends
                            shift_r  <= reg_rd_data_in;
                            sda_oe_r <= !reg_rd_data_in[7];
                            state_r  <= ST_RD_BYTE;
                        end
                        else
                        begin
                            sda_oe_r <= 1'b0;
                            state_r  <= ST_WR_BYTE;
                        end
                    end
                end
                ST_WR_BYTE:
                begin
                    if (scl_rise)
                    begin
                        shift_r   <= {shift_r[6:0], sda_now};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        if (byte_idx_r == IDX_POINTER)
                        begin
                            ptr_r    <= shift_r;
                            sda_oe_r <= 1'b1;
                        end
                        else
                            sda_oe_r <= wr_push;
                        state_r <= ST_WR_ACK;
                    end
                end
                ST_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_r  <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        // a third byte or a refused one is not acknowledged
                        if (sda_oe_r && byte_idx_r != IDX_EXTRA)
                        begin
                            byte_idx_r <= byte_idx_r + 2'h1;
                            state_r    <= ST_WR_BYTE;
                        end
                        else
                            state_r    <= ST_IGNORE;
                    end
                end
                ST_RD_BYTE:
                begin
                    if (scl_rise)
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    else if (byte_done)
                    begin
                        sda_oe_r <= 1'b0;
                        state_r  <= ST_RD_ACK;
                    end
                    else if (scl_fall)
                    begin
                        shift_r  <= {shift_r[6:0], 1'b0};
                        sda_oe_r <= !shift_r[6];
                    end
                end
                ST_RD_ACK:
                begin
                    // one byte per read, whatever the master answers
                    if (scl_rise)
                        state_r <= ST_IGNORE;
                end
                default:
                begin
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // open drain: only ever pull low
    assign sda_out         = 1'b0;
    assign sda_oe_out      = sda_oe_r;
    assign reg_pointer_out = ptr_r;

    ////////////////////////////////////////////////////////////////////////
    // writes queue toward the register file; reads do not wait for it,
    // so a read right after a write may see the old value if it stalls
    reg_write_fifo #(
        .WIDTH ($bits(reg_write_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (wr_push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (wr_cmd),
        .out_valid_out (reg_wr_valid_out),
        .out_ready_in  (reg_wr_ready_in),
        .out_data_out  (reg_wr_out)
    );

endmodule // smbus_register_access_slave

// ==== src/smbus_slave_pkg.sv ====
// constants, command struct and state enum for the serial register slave
package smbus_slave_pkg;

    // fixed upper part of the 7-bit slave address
    localparam logic [4:0] ADDR_FIXED    = 5'h0b;
    // low address bits for each state of the three-state select pin
    localparam logic [1:0] LOW_FOR_GND   = 2'h2;
    localparam logic [1:0] LOW_FOR_OPEN  = 2'h0;
    localparam logic [1:0] LOW_FOR_VCC   = 2'h1;
    // pad detector codes for the select pin
    localparam logic [1:0] SEL_GND       = 2'h0;
    localparam logic [1:0] SEL_OPEN      = 2'h1;
    localparam logic [1:0] SEL_VCC       = 2'h2;
    // field layout and counts
    localparam int         BYTE_W        = 8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] IDX_POINTER   = 2'h0;
    localparam logic [1:0] IDX_DATA      = 2'h1;
    localparam logic [1:0] IDX_EXTRA     = 2'h2;
    localparam logic [7:0] POINTER_RESET = 8'h00;
    // cycles after reset release before the select pin is caught
    localparam logic [2:0] SEL_SETTLE    = 3'h4;
    // depth of the data-path fifo
    localparam int         WR_FIFO_DEPTH = 16;

    // one register write: pointer value and data byte
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_s;

    typedef enum {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK,
        ST_IGNORE
    } bus_state_e;

endpackage

// ==== sim/smbus_master_model.sv ====
// behavioural bus master that drives the link clock and data line
`timescale 1ns/100ps
module smbus_master_model (
    input  wire logic core_clk_in,
    input  wire logic sda_bus_in,
    output logic      scl_out,
    output logic      sda_drv_out
);
    // idle bus: clock stands high, data released to the pull-up
    initial
    begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    // 800 ns bit: long low phase, since the slave answers late in it
    task automatic bit_xfer(input logic b, output logic got);
        scl_out = 1'b0;
        cyc(2);
        sda_drv_out = b;
        cyc(3);
        scl_out = 1'b1;
        cyc(2);
        got = sda_bus_in;
        cyc(1);
    endtask
    // data falls while clock high, also used as repeated start
    task automatic start();
        scl_out = 1'b0;
        cyc(5);
        sda_drv_out = 1'b1;
        cyc(2);
        scl_out = 1'b1;
        cyc(4);
        sda_drv_out = 1'b0;
        cyc(4);
    endtask
    // data low in the low phase, then rises while clock high
    task automatic stop();
        scl_out = 1'b0;
        cyc(5);
        sda_drv_out = 1'b0;
        cyc(2);
        scl_out = 1'b1;
        cyc(4);
        sda_drv_out = 1'b1;
        cyc(4);
    endtask
    // eight bits msb first, then the slave's acknowledge slot
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_xfer(b[i], g);
        bit_xfer(1'b1, g);
        ack = !g;
    endtask
    // read one byte and answer with no-acknowledge
    task automatic rbyte(output logic [7:0] b);
        logic g;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, b[i]);
        bit_xfer(1'b1, g);
    endtask
endmodule // smbus_master_model

// ==== sim/smbus_slave_checker.sv ====
// assertion checker on the bus slave's top-level ports
`timescale 1ns/100ps
module smbus_slave_checker
    import smbus_slave_pkg::*;
(
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic [7:0] reg_pointer_out,
    input wire logic       reg_wr_valid_out,
    input wire logic       reg_wr_ready_in,
    input wire reg_write_s reg_wr_out,
    input wire logic [6:0] own_addr_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////
    // cycles since reset release; saturates well past the latch point
    logic [3:0] since_r;
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
            since_r <= 4'h0;
        else if (since_r != 4'hf)
            since_r <= since_r + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////
    property p_fixed;
        own_addr_out[6:2] == 5'h0b;
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("address prefix wrong");
    property p_latch;
        since_r == 4'hf |-> $stable(own_addr_out);
    endproperty
    a_latch: assert property (p_latch)
        else $error("address moved after power-up");
    property p_open_drain;
        sda_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data driven high");
    property p_oe_edge;
        $changed(sda_oe_out) |-> !scl_in;
    endproperty
    a_oe_edge: assert property (p_oe_edge)
        else $error("data moved while clock high");
    property p_ptr_ack;
        $changed(reg_pointer_out) |-> $rose(sda_oe_out);
    endproperty
    a_ptr_ack: assert property (p_ptr_ack)
        else $error("pointer moved outside an ack");
    property p_push;
        $rose(reg_wr_valid_out) |-> sda_oe_out;
    endproperty
    a_push: assert property (p_push)
        else $error("write word without data ack");
    property p_hold;
        reg_wr_valid_out && !reg_wr_ready_in
            |=> reg_wr_valid_out && $stable(reg_wr_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("write word dropped before taken");
    property p_reset;
        $rose(rst_n_in) |-> !sda_oe_out && !reg_wr_valid_out
            && reg_pointer_out == 8'h00;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");
endmodule // smbus_slave_checker

bind smbus_register_access_slave smbus_slave_checker chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .reg_pointer_out(reg_pointer_out),
    .reg_wr_valid_out(reg_wr_valid_out),
    .reg_wr_ready_in(reg_wr_ready_in), .reg_wr_out(reg_wr_out),
    .own_addr_out(own_addr_out)
);

// ==== sim/tb_top.sv ====
// testbench for the bus slave: scenarios, register side, verdict
`timescale 1ns/100ps
module tb_top;
    import smbus_slave_pkg::*;
    localparam logic [6:0] ADDR = 7'h2c;
    logic       core_clk_in = 1'b0;
    logic       rst_n_in    = 1'b0;
    logic [1:0] sel         = 2'h1;
    logic       wr_ready    = 1'b1;
    logic       scl, sda_drv, sda_oe, sda_o, wr_valid;
    wire        sda_bus;
    logic [7:0] ptr, rd_data;
    logic [6:0] own;
    reg_write_s wr_word;
    reg_write_s taken[$];
    int         fail_count = 0;
    int         n_checks   = 0;

    always #50 core_clk_in = ~core_clk_in;
    // pull-up: the line is low only while someone pulls it
    assign sda_bus = sda_oe ? 1'b0 : sda_drv;
    // register file model: contents derived from the pointer
    assign rd_data = ptr ^ 8'h5a;
    always @(posedge core_clk_in)
        if (wr_valid === 1'b1 && wr_ready)
            taken.push_back(wr_word);

    smbus_register_access_slave #(.FIFO_DEPTH(2)) uut (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .address_select_pin_in(sel), .scl_in(scl), .sda_in(sda_bus),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .reg_pointer_out(ptr),
        .reg_rd_data_in(rd_data), .reg_wr_valid_out(wr_valid),
        .reg_wr_ready_in(wr_ready), .reg_wr_out(wr_word),
        .own_addr_out(own)
    );
    smbus_master_model master (
        .core_clk_in(core_clk_in), .sda_bus_in(sda_bus),
        .scl_out(scl), .sda_drv_out(sda_drv)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic addr_phase(input logic rw, output logic ack);
        master.start();
        master.wbyte({ADDR, rw}, ack);
    endtask
    ////////////////////////////////////////////////////////////////////
    // each pin code through a reset; later pin moves must not matter
    task automatic t_select();
        logic [1:0] codes[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
        logic [1:0] lows[4]  = '{2'h2, 2'h1, 2'h0, 2'h0};
        for (int i = 0; i < 4; i++)
        begin
            sel = codes[i];
            rst_n_in = 1'b0;
            cyc(20);
            rst_n_in = 1'b1;
            cyc(20);
            check(16'({5'h0b, lows[i]}), 16'(own));
            sel = ~codes[i];
            cyc(20);
            check(16'({5'h0b, lows[i]}), 16'(own));
        end
    endtask
    task automatic t_mismatch();
        logic a;
        master.start();
        master.wbyte({7'h2d, 1'b0}, a);
        check(16'(a), 16'h0);
        master.wbyte(8'h77, a);
        check(16'(a), 16'h0);
        master.stop();
        check(16'(ptr), 16'h0);
    endtask
    // pointer then data; a third byte is refused
    task automatic t_write_two();
        logic a;
        taken.delete();
        addr_phase(1'b0, a);
        check(16'(a), 16'h1);
        master.wbyte(8'h12, a);
        check(16'(ptr), 16'h12);
        master.wbyte(8'ha5, a);
        check(16'(a), 16'h1);
        master.wbyte(8'h3c, a);
        check(16'(a), 16'h0);
        master.stop();
        check(16'(taken.size()), 16'h1);
        check(taken[0], 16'h12a5);
    endtask
    task automatic t_ptr_only();
        logic a;
        taken.delete();
        addr_phase(1'b0, a);
        master.wbyte(8'h34, a);
        master.stop();
        cyc(8);
        check(16'(ptr), 16'h34);
        check(16'(taken.size()), 16'h0);
    endtask
    task automatic t_read_old();
        logic a;
        logic [7:0] b;
        addr_phase(1'b1, a);
        check(16'(a), 16'h1);
        master.rbyte(b);
        master.stop();
        check(16'(b), 16'(8'h34 ^ 8'h5a));
    endtask
    task automatic t_read_byte();
        logic a;
        logic [7:0] b;
        addr_phase(1'b0, a);
        master.wbyte(8'h56, a);
        addr_phase(1'b1, a);
        check(16'(a), 16'h1);
        master.rbyte(b);
        master.stop();
        check(16'(b), 16'(8'h56 ^ 8'h5a));
    endtask
    // stalled register side: third data byte refused, then drain
    task automatic t_fifo_full();
        logic a;
        taken.delete();
        wr_ready = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            addr_phase(1'b0, a);
            master.wbyte(8'h40 + 8'(k), a);
            master.wbyte(8'hc0 + 8'(k), a);
            check(16'(a), 16'(k < 2));
            master.stop();
        end
        check(16'(ptr), 16'h42);
        check(16'(wr_valid), 16'h1);
        wr_ready = 1'b1;
        cyc(6);
        check(16'(taken.size()), 16'h2);
        check(taken[1], 16'h41c1);
        check(16'(wr_valid), 16'h0);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc(20);
        rst_n_in = 1'b1;
        t_select();
        t_mismatch();
        t_write_two();
        t_ptr_only();
        t_read_old();
        t_read_byte();
        t_fifo_full();
        end_sim();
    end
    // hang guard, far beyond the few thousand cycles of the run
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule // tb_top
